// ===== inc/prc_pkg.sv
`default_nettype none

package prc_pkg;

   // timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned BASE_HZ       = 50_000;
   localparam int unsigned BASE_DIV_CYC  = CLK_HZ / BASE_HZ;
   localparam int unsigned SCAN_HZ       = 1;
   localparam int unsigned SCAN_STEP_CYC = CLK_HZ / SCAN_HZ;

   // channels and scanner positions
   localparam int unsigned NCHAN    = 11;
   localparam logic [3:0]  HOME_POS = 4'hb;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_CFG   = 8'h04;
   localparam logic [7:0] OFF_STAT  = 8'h08;
   localparam logic [7:0] OFF_SCAN  = 8'h0c;
   localparam logic [7:0] OFF_COUNT = 8'h40;
   localparam logic [7:0] CNT_MASK  = 8'hc3;

   // control bits (write pulses)
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_STOP  = 1;
   localparam int unsigned CTRL_CLEAR = 2;

   // configuration fields
   localparam int unsigned CFG_WIDTH_LSB = 0;
   localparam int unsigned CFG_DELAY_LSB = 8;
   localparam int unsigned CFG_CYC_LSB   = 12;
   localparam int unsigned CFG_RATE_LSB  = 16;
   localparam logic [6:0]  WIDTH_RST     = 7'h01;
   localparam logic [6:0]  WIDTH_MAX     = 7'h64;
   localparam logic [3:0]  DELAY_RST     = 4'h1;
   localparam logic [3:0]  DELAY_MAX     = 4'ha;
   localparam logic [1:0]  CYC_RST       = 2'h0;
   localparam logic [3:0]  RATE_RST      = 4'h1;
   localparam logic [3:0]  RATE_MAX      = 4'ha;

   // run lengths
   localparam logic [9:0] RUN_10   = 10'h00a;
   localparam logic [9:0] RUN_100  = 10'h064;
   localparam logic [9:0] RUN_1000 = 10'h3e8;

   typedef enum logic [3:0] {
      SEQ_IDLE  = 4'b0001,
      SEQ_WAIT  = 4'b0010,
      SEQ_DELAY = 4'b0100,
      SEQ_GATE  = 4'b1000
   } seq_state_t;

endpackage

`default_nettype wire

// ===== inc/scan_if.sv
`timescale 1ns/1ns
`default_nettype none

interface scan_if;
   logic       start;
   logic       manual;
   logic       all_open;
   logic [3:0] pos;
   logic       coil;
   modport ctl (output start, output manual, output all_open,
                input pos, input coil);
   modport scn (input start, input manual, input all_open,
                output pos, output coil);
endinterface

`default_nettype wire

// ===== rtl/pulsed_reactivity_count_sequencer.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module pulsed_reactivity_count_sequencer #(
   parameter int unsigned CNT_W    = 20,
   parameter int unsigned STEP_CYC = prc_pkg::SCAN_STEP_CYC,
   parameter int unsigned BASE_CYC = prc_pkg::BASE_DIV_CYC,
   parameter int unsigned REP_ACC  = prc_pkg::BASE_HZ
) (
   // clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   // apb slave
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [7:0]              paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic      [31:0]             prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // pins
   input  wire logic                    detector_i,
   input  wire logic                    scan_start_button_i,
   input  wire logic                    manual_scan_select_i,
   input  wire logic [2:0]              interrupter_open_i,
   output logic                         pulsed_source_trigger_o,
   output logic                         operate_o,
   output logic [prc_pkg::NCHAN-1:0]    gate_stage_o,
   output logic                         scan_coil_o,
   output logic [3:0]                   scan_pos_o,
   output logic [CNT_W-1:0]             scan_count_o
);
   import prc_pkg::*;

   function automatic logic [6:0] clamp(input logic [6:0] v,
                                        input logic [6:0] mx);
      if (v == 7'h00) return 7'h01;
      else if (v > mx) return mx;
      else return v;
   endfunction

   // pin synchronisers
   logic [5:0] pin_raw;
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic       det_prev_q;
   logic       det_pulse;

   assign pin_raw = {interrupter_open_i, manual_scan_select_i,
                     scan_start_button_i, detector_i};

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q    <= 6'h00;
         sync2_q    <= 6'h00;
         det_prev_q <= 1'b0;
      end else begin
         sync1_q    <= pin_raw;
         sync2_q    <= sync1_q;
         det_prev_q <= sync2_q[0];
      end
   end
   assign det_pulse = sync2_q[0] & ~det_prev_q;

   // apb decode
   logic       acc;
   logic       wr_fire;
   logic       sel_ctrl;
   logic       sel_cfg;
   logic       sel_stat;
   logic       sel_scan;
   logic       sel_cnt;
   logic       mapped;
   logic [3:0] cnt_idx;
   logic       pready_q;
   logic       pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_word;

   assign acc      = psel_i & penable_i & ~pready_q;
   assign wr_fire  = psel_i & penable_i & pready_q & pwrite_i;
   assign sel_ctrl = paddr_i == OFF_CTRL;
   assign sel_cfg  = paddr_i == OFF_CFG;
   assign sel_stat = paddr_i == OFF_STAT;
   assign sel_scan = paddr_i == OFF_SCAN;
   assign cnt_idx  = paddr_i[5:2];
   assign sel_cnt  = ((paddr_i & CNT_MASK) == OFF_COUNT) &&
                     (cnt_idx < 4'(NCHAN));
   assign mapped   = sel_ctrl | sel_cfg | sel_stat | sel_scan | sel_cnt;

   logic start_wr;
   logic stop_wr;
   logic clr_wr;
   assign start_wr = wr_fire & sel_ctrl & pwdata_i[CTRL_START];
   assign stop_wr  = wr_fire & sel_ctrl & pwdata_i[CTRL_STOP];
   assign clr_wr   = wr_fire & sel_ctrl & pwdata_i[CTRL_CLEAR];

   // configuration
   logic [6:0] width_q;
   logic [3:0] delay_q;
   logic [1:0] cyc_sel_q;
   logic [3:0] rate_q;
   logic [6:0] width_sel;
   logic [6:0] delay_c;
   logic [6:0] rate_c;
   logic [3:0] delay_sel;
   logic [3:0] rate_sel;
   logic [9:0] target;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         width_q   <= WIDTH_RST;
         delay_q   <= DELAY_RST;
         cyc_sel_q <= CYC_RST;
         rate_q    <= RATE_RST;
      end else if (wr_fire && sel_cfg) begin
         width_q   <= pwdata_i[CFG_WIDTH_LSB +: 7];
         delay_q   <= pwdata_i[CFG_DELAY_LSB +: 4];
         cyc_sel_q <= pwdata_i[CFG_CYC_LSB +: 2];
         rate_q    <= pwdata_i[CFG_RATE_LSB +: 4];
      end
   end

   assign width_sel = clamp(width_q, WIDTH_MAX);
   assign delay_c   = clamp({3'h0, delay_q}, {3'h0, DELAY_MAX});
   assign rate_c    = clamp({3'h0, rate_q}, {3'h0, RATE_MAX});
   assign delay_sel = delay_c[3:0];
   assign rate_sel  = rate_c[3:0];
   assign target    = (cyc_sel_q == 2'h0) ? RUN_10 :
                      (cyc_sel_q == 2'h1) ? RUN_100 : RUN_1000;

   // base tick, channel width and repetition timing
   localparam int unsigned BW = $clog2(BASE_CYC);
   logic [BW-1:0] base_q;
   logic          base_tick;
   logic [6:0]    wdiv_q;
   logic          width_tick;
   logic [16:0]   acc_q;
   logic [16:0]   rep_sum;
   logic          rep_tick;
   logic          trig;

   assign base_tick  = base_q == BW'(BASE_CYC - 1);
   assign width_tick = base_tick & (wdiv_q == width_sel - 7'h01);
   assign rep_sum    = acc_q + {13'h0000, rate_sel};
   assign rep_tick   = base_tick & (rep_sum >= 17'(REP_ACC));

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         base_q <= '0;
         wdiv_q <= 7'h00;
         acc_q  <= 17'h00000;
      end else begin
         base_q <= base_tick ? '0 : base_q + BW'(1);
         if (trig || width_tick) begin
            wdiv_q <= 7'h00;
         end else if (base_tick) begin
            wdiv_q <= wdiv_q + 7'h01;
         end
         if (base_tick) begin
            acc_q <= rep_tick ? rep_sum - 17'(REP_ACC) : rep_sum;
         end
      end
   end

   // measuring sequence
   seq_state_t      state_q;
   seq_state_t      state_d;
   logic [3:0]      dcnt_q;
   logic [9:0]      cyc_q;
   logic            done_q;
   logic            stop_q;
   logic            halt;
   logic            cyc_end;
   logic            last_cyc;
   logic            trig_q;
   logic            operate_q;
   logic [NCHAN-1:0] stage_q;

   assign cyc_end  = (state_q == SEQ_GATE) & width_tick &
                     stage_q[NCHAN-1];
   assign last_cyc = (cyc_q + 10'h001) == target;
   assign trig     = (state_q == SEQ_WAIT) & rep_tick & ~stop_q & ~clr_wr;
   assign halt     = (state_q != SEQ_IDLE) & (state_d == SEQ_IDLE);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SEQ_IDLE: begin
            if (start_wr && !done_q) state_d = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (stop_q) state_d = SEQ_IDLE;
            else if (rep_tick) begin
               state_d = (delay_sel == 4'h1) ? SEQ_GATE : SEQ_DELAY;
            end
         end
         SEQ_DELAY: begin
            if (width_tick && (dcnt_q + 4'h1 == delay_sel - 4'h1)) begin
               state_d = SEQ_GATE;
            end
         end
         SEQ_GATE: begin
            if (cyc_end) begin
               state_d = (last_cyc || stop_q) ? SEQ_IDLE : SEQ_WAIT;
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
      if (clr_wr) state_d = SEQ_IDLE;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q   <= SEQ_IDLE;
         trig_q    <= 1'b0;
         operate_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         trig_q    <= trig;
         operate_q <= state_d != SEQ_IDLE;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dcnt_q  <= 4'h0;
         cyc_q   <= 10'h000;
         done_q  <= 1'b0;
         stop_q  <= 1'b0;
         stage_q <= NCHAN'(1);
      end else if (clr_wr) begin
         dcnt_q  <= 4'h0;
         cyc_q   <= 10'h000;
         done_q  <= 1'b0;
         stop_q  <= 1'b0;
         stage_q <= NCHAN'(1);
      end else begin
         if (trig) dcnt_q <= 4'h0;
         else if (state_q == SEQ_DELAY && width_tick) dcnt_q <= dcnt_q + 4'h1;
         if (cyc_end) begin
            cyc_q <= cyc_q + 10'h001;
            if (last_cyc) done_q <= 1'b1;
         end
         // a stop write in the halting cycle stays pending
         stop_q <= stop_wr | (stop_q & ~halt & ~start_wr);
         if (state_q == SEQ_GATE && width_tick) begin
            stage_q <= {stage_q[NCHAN-2:0], stage_q[NCHAN-1]};
         end
      end
   end

   // channel counters
   logic [CNT_W-1:0] cnt_q [NCHAN];
   logic [NCHAN-1:0] hit;

   genvar gi;
   generate
      for (gi = 0; gi < NCHAN; gi++) begin : g_chan
         assign hit[gi] = det_pulse & stage_q[gi] & (state_q != SEQ_IDLE);
         always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               cnt_q[gi] <= '0;
            end else if (clr_wr) begin
               cnt_q[gi] <= '0;
            end else if (hit[gi]) begin
               cnt_q[gi] <= cnt_q[gi] + CNT_W'(1);
            end
         end
      end
   endgenerate

   // scanner
   scan_if sc_if ();
   logic [CNT_W-1:0] scan_cnt_q;

   assign sc_if.start    = sync2_q[1];
   assign sc_if.manual   = sync2_q[2];
   assign sc_if.all_open = &sync2_q[5:3];

   step_scanner #(
      .STEP_CYC (STEP_CYC)
   ) u_scan (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .sc      (sc_if.scn)
   );

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scan_cnt_q <= '0;
      end else begin
         scan_cnt_q <= (sc_if.pos < 4'(NCHAN)) ? cnt_q[sc_if.pos] : '0;
      end
   end

   // register read and answer
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   assign cfg_word  = {12'h000, rate_q, 2'h0, cyc_sel_q, delay_q,
                       1'b0, width_q};
   assign stat_word = {11'h000, sc_if.coil, sc_if.pos, 2'h0, cyc_q,
                       1'b0, stop_q, done_q, operate_q};
   assign rd_word   = sel_cfg  ? cfg_word :
                      sel_stat ? stat_word :
                      sel_scan ? {{(32-CNT_W){1'b0}}, scan_cnt_q} :
                      sel_cnt  ? {{(32-CNT_W){1'b0}}, cnt_q[cnt_idx]} :
                      32'h0000_0000;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc & ~mapped;
         if (acc && !pwrite_i) prdata_q <= rd_word;
      end
   end

   assign prdata_o                = prdata_q;
   assign pready_o                = pready_q;
   assign pslverr_o               = pslverr_q;
   assign pulsed_source_trigger_o = trig_q;
   assign operate_o               = operate_q;
   assign gate_stage_o            = stage_q;
   assign scan_coil_o             = sc_if.coil;
   assign scan_pos_o              = sc_if.pos;
   assign scan_count_o            = scan_cnt_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   property p_gate_and;
      hit[1] && !clr_wr |=> cnt_q[1] == $past(cnt_q[1]) + CNT_W'(1);
   endproperty
   a_gate_and: assert property (p_gate_and)
      else $error("gated pulse not counted in channel one");

   property p_width;
      width_tick |-> base_tick && wdiv_q == width_sel - 7'h01;
   endproperty
   a_width: assert property (p_width)
      else $error("width tick off the divided base");

   property p_delay_one;
      trig && delay_sel == 4'h1 |=> state_q == SEQ_GATE && stage_q[0];
   endproperty
   a_delay_one: assert property (p_delay_one)
      else $error("unit delay did not gate at once");

   property p_trig_rep;
      trig_q |-> $past(rep_tick) && $past(state_q) == SEQ_WAIT;
   endproperty
   a_trig_rep: assert property (p_trig_rep)
      else $error("trigger without repetition tick");

   property p_run_end;
      cyc_end && last_cyc && !clr_wr |=> done_q && state_q == SEQ_IDLE
         ##1 !operate_o;
   endproperty
   a_run_end: assert property (p_run_end)
      else $error("run did not end at preset count");

   property p_operate;
      operate_o == (state_q != SEQ_IDLE);
   endproperty
   a_operate: assert property (p_operate)
      else $error("operate output disagrees with run state");

   property p_stop_wait;
      stop_q && state_q == SEQ_DELAY && !clr_wr |=> state_q != SEQ_IDLE;
   endproperty
   a_stop_wait: assert property (p_stop_wait)
      else $error("stop aborted a cycle in progress");

   property p_resume;
      state_q == SEQ_IDLE && start_wr && !done_q && !clr_wr
         |=> state_q == SEQ_WAIT && cyc_q == $past(cyc_q);
   endproperty
   a_resume: assert property (p_resume)
      else $error("start did not resume the run");

   property p_clear;
      clr_wr |=> state_q == SEQ_IDLE && cyc_q == 10'h000 && !done_q;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left sequencing state");

   property p_hold_idle;
      state_q == SEQ_IDLE && !clr_wr |=> $stable(cnt_q[5]);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("count changed outside a run");

   property p_onehot;
      $onehot(stage_q);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("gating stages not one-hot");

   property p_gate_closed;
      done_q && start_wr && !clr_wr && state_q == SEQ_IDLE
         |=> state_q == SEQ_IDLE;
   endproperty
   a_gate_closed: assert property (p_gate_closed)
      else $error("start accepted after run complete");

   c_trigger: cover property (trig_q);
   c_done: cover property ($rose(done_q));
   c_stop_halt: cover property (halt && stop_q);
endmodule

`default_nettype wire

// ===== rtl/step_scanner.sv
`timescale 1ns/1ns
`default_nettype none

module step_scanner #(
   parameter int unsigned STEP_CYC = prc_pkg::SCAN_STEP_CYC
) (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   // scanner signals
   scan_if.scn       sc
);
   import prc_pkg::*;

   localparam int unsigned OW = $clog2(STEP_CYC + 1);

   logic [OW-1:0] osc_q;
   logic          osc_tick;
   logic          set_ok;
   logic          step_q;
   logic [3:0]    pos_q;
   logic          done_step;

   assign osc_tick  = osc_q == OW'(STEP_CYC - 1);
   // set path: start bridges the off-normal contact, manual opens it
   assign set_ok    = sc.start | (~sc.manual & (pos_q != HOME_POS));
   assign done_step = step_q & sc.all_open;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         osc_q <= '0;
      end else begin
         osc_q <= osc_tick ? '0 : osc_q + OW'(1);
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         step_q <= 1'b0;
         pos_q  <= HOME_POS;
      end else begin
         step_q <= (osc_tick & set_ok) | (step_q & ~sc.all_open);
         if (done_step) begin
            pos_q <= (pos_q == HOME_POS) ? 4'h0 : pos_q + 4'h1;
         end
      end
   end

   assign sc.pos  = pos_q;
   assign sc.coil = step_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   property p_step_hold;
      step_q && !sc.all_open |=> step_q;
   endproperty
   a_step_hold: assert property (p_step_hold)
      else $error("step cleared before contacts open");

   property p_home_block;
      !step_q && osc_tick && pos_q == HOME_POS && !sc.start |=> !step_q;
   endproperty
   a_home_block: assert property (p_home_block)
      else $error("step taken from home without start");

   property p_manual_hold;
      !step_q && sc.manual && !sc.start |=> !step_q;
   endproperty
   a_manual_hold: assert property (p_manual_hold)
      else $error("manual scan stepped without start");

   property p_advance;
      done_step && !osc_tick && pos_q == 4'h3 |=> pos_q == 4'h4 && !step_q;
   endproperty
   a_advance: assert property (p_advance)
      else $error("scanner did not advance one position");

   c_wrap_home: cover property (done_step && pos_q == 4'ha);
endmodule

`default_nettype wire

// ===== testbench/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none

// source, detector and stepping switch contacts seen from the block
module far_side_model #(
   parameter int unsigned OPEN_GAP = 3
) (
   // clock
   input  wire logic       clock_i,
   // source and detector
   input  wire logic       trigger_i,
   output logic            detector_o,
   // stepping switch
   input  wire logic       coil_i,
   output logic [2:0]      contacts_open_o
);
   int unsigned coil_cnt = 0;
   int unsigned burst_cnt = 0;

   initial begin
      detector_o      = 1'b0;
      contacts_open_o = 3'h0;
   end

   // contacts open one after another, so a step needs all three
   always @(posedge clock_i) begin
      coil_cnt <= coil_i ? coil_cnt + 1 : 0;
      for (int k = 0; k < 3; k++) begin
         contacts_open_o[k] <= coil_i && coil_cnt >= OPEN_GAP * (k + 1);
      end
   end

   // a burst of detector pulses follows each trigger
   always @(posedge clock_i) begin
      burst_cnt  <= trigger_i ? 40 : (burst_cnt != 0 ? burst_cnt - 1 : 0);
      detector_o <= burst_cnt[2];
   end
endmodule

`default_nettype wire

// ===== testbench/tb_pulsed_reactivity_count_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module tb_pulsed_reactivity_count_sequencer;
   import prc_pkg::*;

   localparam int unsigned STEP = 50;

   logic        clock_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, detector, trigger, operate, coil;
   logic        button = 1'b0, manual = 1'b0, coil_seen = 1'b0;
   logic [2:0]  contacts;
   logic [10:0] stage;
   logic [3:0]  pos, pos_seen = 4'hb;
   logic [19:0] count;
   int          error_cnt = 0, tests_run = 0, moves = 0;
   time         last_move = 0;
   logic [31:0] cfg_in [3] = '{32'h0, 32'h000f_2f7f, 32'h0005_1a64};

   always #10 clock_i = ~clock_i;

   pulsed_reactivity_count_sequencer #(.STEP_CYC(STEP), .BASE_CYC(4),
                                       .REP_ACC(500))
      pulsed_reactivity_count_sequencer_i (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .detector_i(detector),
      .scan_start_button_i(button), .manual_scan_select_i(manual),
      .interrupter_open_i(contacts), .pulsed_source_trigger_o(trigger),
      .operate_o(operate), .gate_stage_o(stage), .scan_coil_o(coil),
      .scan_pos_o(pos), .scan_count_o(count));

   far_side_model far_side_model_i (
      .clock_i(clock_i), .trigger_i(trigger), .detector_o(detector),
      .coil_i(coil), .contacts_open_o(contacts));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge clock_i);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         chk("apb ready", 32'h1, 32'h0);
         summarize();
      end else begin
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(1'b1, a, d, v, e);
      repeat (3) @(posedge clock_i);
   endtask

   task automatic rd(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
      logic [31:0] v;
      logic        e;
      apb(1'b0, a, 32'h0, v, e);
      chk(what, exp, v);
   endtask

   task automatic wait_pos(input logic [3:0] p, input int lim);
      for (int n = 0; n < lim && pos !== p; n++) begin
         @(posedge clock_i);
      end
      chk("scanner position", 32'(p), 32'(pos));
      if (pos !== p) begin
         summarize();
      end
   endtask

   task automatic wait_idle(input int lim);
      for (int n = 0; n < lim && operate !== 1'b0; n++) begin
         @(posedge clock_i);
      end
      chk("operate at run end", 32'h0, 32'(operate));
      if (operate !== 1'b0) begin
         summarize();
      end
   endtask

   // step spacing and the contact condition at each step
   always @(posedge clock_i) begin
      if (rst_b_i && pos !== pos_seen) begin
         if (moves >= 2 && !manual) begin
            chk("step period", 32'(STEP * 20), 32'($time - last_move));
         end
         moves++;
         last_move = $time;
      end
      if (coil_seen === 1'b1 && coil === 1'b0) begin
         chk("contacts at step", 32'h7, 32'(contacts));
      end
      pos_seen  = pos;
      coil_seen = coil;
   end

   initial begin
      #2_000_000;
      chk("run time", 32'h0, 32'h1);
      summarize();
   end

   initial begin
      logic [31:0] v;
      logic        e;
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      chk("gate stage", 32'h1, 32'(stage));
      rd("config", OFF_CFG, 32'h0001_0101);
      rd("status", OFF_STAT, 32'h000b_0000);
      for (int i = 0; i < 11; i++) begin
         rd("channel count", OFF_COUNT + 8'(4 * i), 32'h0);
      end
      $display("reset state test done");
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CFG, cfg_in[i]);
         rd("config readback", OFF_CFG, cfg_in[i]);
      end
      wr(OFF_STAT, 32'hffff_ffff);
      rd("control", OFF_CTRL, 32'h0);
      apb(1'b0, 8'h10, 32'h0, v, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, v);
      $display("register test done");
      wr(OFF_CTRL, 32'(1) << CTRL_START);
      chk("operate", 32'h1, 32'(operate));
      rd("status running", OFF_STAT, 32'h000b_0001);
      wr(OFF_CTRL, 32'(1) << CTRL_STOP);
      chk("operate after stop", 32'h0, 32'(operate));
      wr(OFF_CTRL, 32'(1) << CTRL_START);
      chk("operate resumed", 32'h1, 32'(operate));
      wr(OFF_CTRL, 32'(1) << CTRL_CLEAR);
      chk("operate after clear", 32'h0, 32'(operate));
      wr(OFF_CTRL, 32'(1) << CTRL_START);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      chk("operate after reset", 32'h0, 32'(operate));
      rd("config after reset", OFF_CFG, 32'h0001_0101);
      $display("run control test done");
      wr(OFF_CFG, 32'h0);
      wr(OFF_CTRL, 32'(1) << CTRL_START);
      wait_idle(25000);
      rd("status done", OFF_STAT, 32'h000b_00a2);
      chk("gate stage idle", 32'h1, 32'(stage));
      for (int i = 0; i < 11; i++) begin
         rd("run count", OFF_COUNT + 8'(4 * i), 32'(i % 2) * 32'ha);
      end
      wr(OFF_CTRL, 32'(1) << CTRL_START);
      chk("start after done", 32'h0, 32'(operate));
      $display("measuring run test done");
      moves = 0;
      button <= 1'b1;
      wait_pos(4'h0, 4 * STEP);
      button <= 1'b0;
      wait_pos(4'hb, 14 * STEP);
      repeat (3 * STEP) @(posedge clock_i);
      chk("steps per scan", 32'd12, 32'(moves));
      chk("home position", 32'hb, 32'(pos));
      chk("count at home", 32'h0, 32'(count));
      $display("continuous scan test done");
      manual <= 1'b1;
      button <= 1'b1;
      wait_pos(4'h3, 6 * STEP);
      button <= 1'b0;
      repeat (4 * STEP) @(posedge clock_i);
      chk("manual hold", 32'h3, 32'(pos));
      chk("scan count", 32'ha, 32'(count));
      rd("scan register", OFF_SCAN, 32'ha);
      rd("count after scan", OFF_COUNT + 8'h0c, 32'ha);
      manual <= 1'b0;
      moves = 0;
      wait_pos(4'hb, 12 * STEP);
      $display("manual scan test done");
      summarize();
   end
endmodule

`default_nettype wire
